// file: rtl/vms_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module vms_monitor #(
  parameter int MS_CYC = vms_pkg::MS_CYC_DEF,
  parameter int DLY_UNIT_CYC = vms_pkg::DLY_UNIT_CYC_DEF
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [3:0] regAddr,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  input wire logic cmpHigh,
  output logic [7:0] dacCode,
  output logic [3:0] muxSel,
  output logic refInternal,
  output logic irqOut,
  output logic mgmtIrq_n
);
  import vms_pkg::*;

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0] mcfg_reg;
  logic [7:0] rate_reg;
  logic [7:0] bank_reg;
  logic [15:0] irqEn_reg;
  logic [15:0] mgmtEn_reg;
  logic [NUM_CH-1:0] evt_reg;
  logic [7:0] chCfg_reg [NUM_CH];
  logic [7:0] chRead_reg [NUM_CH];
  logic [7:0] chHigh_reg [NUM_CH];
  logic [7:0] chLow_reg [NUM_CH];
  logic [7:0] rdata_reg;
  logic refInt_reg;
  logic irq_reg;
  logic mgmtIrq_n_reg;
  vms_state_e state_reg;
  logic [3:0] chIdx_reg;
  logic [15:0] dlyCnt_reg;
  logic [31:0] msPre_reg;
  logic [7:0] msCnt_reg;
  logic [7:0] sarDac;
  logic sarBusy;
  logic convDone;
  logic [7:0] sarResult;
  logic [NUM_CH-1:0] chEn;

  // ****************************************************************
  // Decode
  // ****************************************************************
  wire wrEvtLo = regWr && (regAddr == ADDR_EVT_LO);
  wire wrEvtHi = regWr && (regAddr == ADDR_EVT_HI);
  wire wrCcfg = regWr && (regAddr == ADDR_CCFG);
  wire wrHlim = regWr && (regAddr == ADDR_HLIM);
  wire wrLlim = regWr && (regAddr == ADDR_LLIM);
  wire standby = mcfg_reg[MCFG_STANDBY];
  wire [2:0] perCode = rate_reg[RATE_PER_LSB +: 3];
  wire [2:0] dlyCode = rate_reg[RATE_DLY_LSB +: 3];
  // Settling delay grows in whole units above code 0
  wire [15:0] dlyCyc = 16'(DLY_UNIT_CYC * (int'(dlyCode) + 1)); // [RULE_06]
  wire periodDone = (msCnt_reg >= PERIOD_MS[perCode]); // [RULE_06]
  wire scanEnd = (chIdx_reg >= 4'(NUM_CH));
  wire chOn = !scanEnd && chEn[chIdx_reg];
  wire convStart = (state_reg == ST_PICK) && !standby && chOn; // [RULE_07]
  wire scanStart = ((state_reg == ST_IDLE) && !standby)
                || ((state_reg == ST_WAIT) && periodDone);
  wire msTick = (msPre_reg == 32'(MS_CYC - 1));
  // Event clear mask, write one to clear a bit of the pair
  wire [15:0] evtClr = wrEvtLo ? {8'h00, regWdata}
                     : wrEvtHi ? {regWdata, 8'h00} : 16'h0000;
  wire [15:0] evtWide = 16'(evt_reg);
  wire bankOk = (bank_reg < 8'(NUM_CH));
  wire [3:0] bankIdx = bank_reg[3:0];

  // ****************************************************************
  // Converter
  // ****************************************************************
  vms_sar u_sar (
    .mclk(mclk),
    .rst_n(rst_n),
    .start(convStart),
    .cmpHigh(cmpHigh),
    .dacCode(sarDac),
    .busy(sarBusy),
    .done(convDone),
    .result(sarResult)
  );

  // ****************************************************************
  // Global registers
  // ****************************************************************
  // Bank select answers in every bank since it sits outside the bank
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mcfg_reg <= MCFG_RST;
      rate_reg <= RATE_RST;
      bank_reg <= BANK_RST; // [RULE_01]
      irqEn_reg <= 16'h0000;
      mgmtEn_reg <= 16'h0000;
    end else if (regWr) begin
      if (regAddr == ADDR_MCFG) mcfg_reg <= regWdata; // [RULE_02] [RULE_03]
      if (regAddr == ADDR_RATE) rate_reg <= regWdata; // [RULE_06]
      if (regAddr == ADDR_BANK) bank_reg <= regWdata; // [RULE_01]
      if (regAddr == ADDR_IRQ_LO) irqEn_reg[7:0] <= regWdata; // [RULE_14]
      if (regAddr == ADDR_IRQ_HI) irqEn_reg[15:8] <= regWdata; // [RULE_14]
      if (regAddr == ADDR_MGMT_LO) mgmtEn_reg[7:0] <= regWdata; // [RULE_15]
      if (regAddr == ADDR_MGMT_HI) mgmtEn_reg[15:8] <= regWdata; // [RULE_15]
    end
  end

  // ****************************************************************
  // Per-channel registers
  // ****************************************************************
  for (genvar gi = 0; gi < NUM_CH; gi++) begin : g_ch
    wire sel = (bank_reg == 8'(gi)); // [RULE_01]
    wire here = convDone && (chIdx_reg == 4'(gi));
    wire chk = here && chCfg_reg[gi][CCFG_ALARM]; // [RULE_11]
    wire hiHit = chk && (sarResult > chHigh_reg[gi]); // [RULE_10] [RULE_23]
    wire loHit = chk && (sarResult < chLow_reg[gi]); // [RULE_10] [RULE_23]
    wire wc = wrCcfg && sel;
    wire [7:0] cfg = chCfg_reg[gi];
    // Hardware set wins over a same-cycle software clear
    wire [7:0] cfgNext = {
      here | (cfg[CCFG_DONE] & ~(wc & regWdata[CCFG_DONE])), // [RULE_08]
      2'b00,
      wc ? regWdata[CCFG_ALARM] : cfg[CCFG_ALARM],
      1'b0,
      loHit | (cfg[CCFG_LOW] & ~(wc & regWdata[CCFG_LOW])), // [RULE_12] [RULE_20]
      hiHit | (cfg[CCFG_HIGH] & ~(wc & regWdata[CCFG_HIGH])), // [RULE_12] [RULE_20]
      wc ? regWdata[CCFG_EN] : cfg[CCFG_EN]}; // [RULE_07]
    wire evtNext = hiHit | loHit | (evt_reg[gi] & ~evtClr[gi]); // [RULE_13] [RULE_20]
    assign chEn[gi] = cfg[CCFG_EN];

    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        chCfg_reg[gi] <= 8'h00;
        chRead_reg[gi] <= 8'h00;
        chHigh_reg[gi] <= HLIM_RST;
        chLow_reg[gi] <= LLIM_RST;
        evt_reg[gi] <= 1'b0;
      end else begin
        chCfg_reg[gi] <= cfgNext;
        evt_reg[gi] <= evtNext;
        if (here) chRead_reg[gi] <= sarResult; // [RULE_09]
        if (wrHlim && sel) chHigh_reg[gi] <= regWdata; // [RULE_10]
        if (wrLlim && sel) chLow_reg[gi] <= regWdata; // [RULE_10]
      end
    end
  end

  // ****************************************************************
  // Scan sequencer
  // ****************************************************************
  // Standby is honoured between conversions so a result is never torn
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      chIdx_reg <= 4'h0;
      dlyCnt_reg <= 16'h0000;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          chIdx_reg <= 4'h0;
          if (!standby) state_reg <= ST_PICK; // [RULE_03]
        end
        ST_PICK: begin
          if (standby) state_reg <= ST_IDLE;
          else if (scanEnd) state_reg <= ST_WAIT; // [RULE_04]
          else if (chOn) state_reg <= ST_CONV; // [RULE_07]
          else chIdx_reg <= chIdx_reg + 4'h1;
        end
        ST_CONV: begin
          dlyCnt_reg <= 16'h0000;
          if (convDone) state_reg <= ST_SETTLE;
        end
        ST_SETTLE: begin
          dlyCnt_reg <= dlyCnt_reg + 16'h0001;
          if (dlyCnt_reg == dlyCyc - 16'h0001) begin // [RULE_05]
            chIdx_reg <= chIdx_reg + 4'h1;
            state_reg <= standby ? ST_IDLE : ST_PICK;
          end
        end
        ST_WAIT: begin
          if (standby) begin
            state_reg <= ST_IDLE;
          end else if (periodDone) begin // [RULE_04]
            chIdx_reg <= 4'h0;
            state_reg <= ST_PICK;
          end
        end
      endcase
    end
  end

  // Period timer restarts with each scan, counted in milliseconds
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      msPre_reg <= 32'h0000_0000;
      msCnt_reg <= 8'h00;
    end else if (scanStart) begin
      msPre_reg <= 32'h0000_0000;
      msCnt_reg <= 8'h00;
    end else begin
      msPre_reg <= msTick ? 32'h0000_0000 : msPre_reg + 32'h0000_0001;
      if (msTick && msCnt_reg != 8'hFF) msCnt_reg <= msCnt_reg + 8'h01;
    end
  end

  // ****************************************************************
  // Read port and outputs
  // ****************************************************************
  wire [7:0] readMux =
      (regAddr == ADDR_EVT_LO) ? evtWide[7:0]
    : (regAddr == ADDR_EVT_HI) ? evtWide[15:8]
    : (regAddr == ADDR_MGMT_HI) ? mgmtEn_reg[15:8]
    : (regAddr == ADDR_MGMT_LO) ? mgmtEn_reg[7:0]
    : (regAddr == ADDR_IRQ_HI) ? irqEn_reg[15:8]
    : (regAddr == ADDR_IRQ_LO) ? irqEn_reg[7:0]
    : (regAddr == ADDR_RATE) ? rate_reg
    : (regAddr == ADDR_MCFG) ? mcfg_reg
    : (regAddr == ADDR_BANK) ? bank_reg
    : !bankOk ? 8'h00
    : (regAddr == ADDR_CCFG) ? chCfg_reg[bankIdx]
    : (regAddr == ADDR_READ) ? chRead_reg[bankIdx] // [RULE_09]
    : (regAddr == ADDR_HLIM) ? chHigh_reg[bankIdx]
    : (regAddr == ADDR_LLIM) ? chLow_reg[bankIdx] : 8'h00;

  // Interrupt levels are registered, one cycle behind the status
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
      refInt_reg <= 1'b0;
      irq_reg <= 1'b0;
      mgmtIrq_n_reg <= 1'b1;
    end else begin
      if (regRd) rdata_reg <= readMux;
      refInt_reg <= ~mcfg_reg[MCFG_EXTREF]; // [RULE_02]
      irq_reg <= |(evtWide & irqEn_reg); // [RULE_14] [RULE_21]
      mgmtIrq_n_reg <= ~|(evtWide & mgmtEn_reg); // [RULE_15] [RULE_21]
    end
  end

  assign regRdata = rdata_reg;
  assign dacCode = sarDac;
  assign muxSel = chIdx_reg;
  assign refInternal = refInt_reg;
  assign irqOut = irq_reg;
  assign mgmtIrq_n = mgmtIrq_n_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic [15:0] gap_reg;
  logic sawDone_reg;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gap_reg <= 16'h0000;
      sawDone_reg <= 1'b0;
    end else begin
      gap_reg <= convDone ? 16'h0000 : gap_reg + 16'(gap_reg != 16'hFFFF);
      sawDone_reg <= (state_reg != ST_IDLE) && (sawDone_reg || convDone);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_leave;
    $fell(standby) ##0 (|chEn) ##0 (state_reg == ST_IDLE);
  endsequence
  sequence s_conv_end;
    convDone && chCfg_reg[chIdx_reg][CCFG_ALARM];
  endsequence

  a_leave_standby: assert property (s_leave |-> ##[1:16] convStart) // [RULE_03]
    else $error("no conversion after leaving standby");
  a_start_enabled: assert property ( // [RULE_07]
    $rose(sarBusy) |-> $past(chCfg_reg[chIdx_reg][CCFG_EN]))
    else $error("conversion of disabled channel");
  a_settle_gap: assert property ( // [RULE_05]
    convStart && sawDone_reg |-> gap_reg >= dlyCyc)
    else $error("settling delay too short");
  a_store_read: assert property (convDone |=> chRead_reg[chIdx_reg] == $past(sarResult)) // [RULE_09]
    else $error("reading not stored");
  a_done_flag: assert property (convDone |=> chCfg_reg[chIdx_reg][CCFG_DONE]) // [RULE_08]
    else $error("done flag not set");
  a_high_flag: assert property (s_conv_end ##0 (sarResult > chHigh_reg[chIdx_reg])
    |=> chCfg_reg[chIdx_reg][CCFG_HIGH] && evt_reg[chIdx_reg]) // [RULE_12]
    else $error("high violation missed");
  a_alarm_gate: assert property (convDone && !chCfg_reg[chIdx_reg][CCFG_ALARM]
    && !wrCcfg |=> $stable(chCfg_reg[chIdx_reg][2:1])) // [RULE_11]
    else $error("flag set with alarm off");
  a_evt_sticky: assert property (evt_reg[0] && !evtClr[0] |=> evt_reg[0]) // [RULE_20]
    else $error("event bit dropped");
  a_irq_level: assert property (|(evtWide & irqEn_reg) |=> irqOut) // [RULE_21]
    else $error("request not raised");
  a_mgmt_level: assert property (!(|(evtWide & mgmtEn_reg)) |=> mgmtIrq_n) // [RULE_15]
    else $error("management interrupt stuck");
  a_standby_idle: assert property (standby && state_reg == ST_WAIT
    |=> state_reg == ST_IDLE) // [RULE_03]
    else $error("scan continued in standby");
endmodule : vms_monitor
`default_nettype wire

// file: rtl/vms_pkg.sv
// Contract
// RULE_01: Bank select register reachable from every bank picks channel; resets to zero.
// RULE_02: External reference by default; config bit 1 at zero selects internal reference.
// RULE_03: Clearing config bit 0 leaves standby and starts sampling enabled channels.
// RULE_04: While active, convert enabled channels in turn, rescanning at the set period.
// RULE_05: Wait the programmed settling delay after every conversion before the next.
// RULE_06: Rate bits 2:0 period, 5:3 delay; period 5 gives 10 ms, delay 0 40 us.
// RULE_07: Channel status bit 0 enables the channel; only enabled channels are scanned.
// RULE_08: Set channel status bit 7 when that channel's conversion completes.
// RULE_09: Keep each channel's latest result in its reading register; full scale is FFh.
// RULE_10: Per-channel writable high and low limits are the comparison thresholds.
// RULE_11: Limit checking happens only while channel status bit 4 is set.
// RULE_12: Above high limit sets bit 1; below low limit sets bit 2.
// RULE_13: A set limit flag also sets that channel's event status bit.
// RULE_14: Interrupt request enable bits per channel let events raise the request.
// RULE_15: Management interrupt enable bits per channel let events raise that output.
// RULE_16: Channel 9 reads the battery undivided; full scale or above reads FFh.
// RULE_17: Software sets the battery channel high limit to FFh.
// RULE_18: Software configures channels before leaving standby.
// RULE_19: Software clears pending channel flags before relying on alarms.
// RULE_20: Limit flags and event bits stay set until software clears them.
// RULE_21: Request output active while any event bit and its enable are both set.
// RULE_22: Each result comes from an eight-bit successive approximation, 0 to 255.
// RULE_23: Compare right after storing; above high or below low is a violation.
package vms_pkg;
  // ****************************************************************
  // Clock and sizes
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int NUM_CH = 11;
  localparam int BATTERY_CH = 9;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [3:0] ADDR_EVT_LO = 4'h0;
  localparam logic [3:0] ADDR_EVT_HI = 4'h1;
  localparam logic [3:0] ADDR_MGMT_HI = 4'h2;
  localparam logic [3:0] ADDR_MGMT_LO = 4'h3;
  localparam logic [3:0] ADDR_IRQ_HI = 4'h4;
  localparam logic [3:0] ADDR_IRQ_LO = 4'h5;
  localparam logic [3:0] ADDR_RATE = 4'h7;
  localparam logic [3:0] ADDR_MCFG = 4'h8;
  localparam logic [3:0] ADDR_BANK = 4'h9;
  localparam logic [3:0] ADDR_CCFG = 4'hA;
  localparam logic [3:0] ADDR_READ = 4'hB;
  localparam logic [3:0] ADDR_HLIM = 4'hC;
  localparam logic [3:0] ADDR_LLIM = 4'hD;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int MCFG_STANDBY = 0;
  localparam int MCFG_EXTREF = 1;
  localparam int CCFG_EN = 0;
  localparam int CCFG_HIGH = 1;
  localparam int CCFG_LOW = 2;
  localparam int CCFG_ALARM = 4;
  localparam int CCFG_DONE = 7;
  localparam int RATE_PER_LSB = 0;
  localparam int RATE_DLY_LSB = 3;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] MCFG_RST = 8'h03;
  localparam logic [7:0] RATE_RST = 8'h05;
  localparam logic [7:0] BANK_RST = 8'h00;
  localparam logic [7:0] HLIM_RST = 8'hFF;
  localparam logic [7:0] LLIM_RST = 8'h00;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int MS_NS = 1000000;
  localparam int MS_CYC_DEF = MS_NS / CLK_PERIOD_NS;
  localparam int DLY_UNIT_NS = 40000;
  localparam int DLY_UNIT_CYC_DEF =
    (DLY_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SAR_STEP_CYC = 4;
  // Scan period in milliseconds for each period code
  localparam logic [7:0] PERIOD_MS [0:7] = '{8'h01, 8'h02, 8'h03, 8'h04,
                                            8'h05, 8'h0A, 8'h14, 8'h32};

  typedef enum logic [2:0] {
    ST_IDLE, ST_PICK, ST_CONV, ST_SETTLE, ST_WAIT
  } vms_state_e;
endpackage : vms_pkg

// file: rtl/vms_sar.sv
`timescale 1ns/1ns
`default_nettype none
module vms_sar #(
  parameter int STEP_CYC = vms_pkg::SAR_STEP_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic cmpHigh,
  output logic [7:0] dacCode,
  output logic busy,
  output logic done,
  output logic [7:0] result
);
  import vms_pkg::*;

  logic cmpMeta_reg;
  logic cmpSync_reg;
  logic [2:0] bitPos_reg;
  logic [7:0] stepCnt_reg;
  logic [7:0] trial_reg;
  logic busy_reg;
  logic done_reg;
  logic [7:0] result_reg;

  // Step ends late enough for the synchronised compare to reflect the DAC
  wire stepEnd = busy_reg && (stepCnt_reg == 8'(STEP_CYC - 1));
  wire [7:0] bitMask = 8'h01 << bitPos_reg;
  wire [7:0] kept = cmpSync_reg ? trial_reg : (trial_reg & ~bitMask);
  wire lastBit = (bitPos_reg == 3'h0);

  // Comparator pin passes two flops before the search reads it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cmpMeta_reg <= 1'b0;
      cmpSync_reg <= 1'b0;
    end else begin
      cmpMeta_reg <= cmpHigh;
      cmpSync_reg <= cmpMeta_reg;
    end
  end

  // Bitwise search from the MSB down, one bit per step
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      bitPos_reg <= 3'h7;
      stepCnt_reg <= 8'h00;
      trial_reg <= 8'h00;
      result_reg <= 8'h00;
    end else begin
      done_reg <= 1'b0;
      if (start && !busy_reg) begin
        busy_reg <= 1'b1;
        bitPos_reg <= 3'h7;
        stepCnt_reg <= 8'h00;
        trial_reg <= 8'h80; // [RULE_22]
      end else if (stepEnd) begin
        stepCnt_reg <= 8'h00;
        bitPos_reg <= bitPos_reg - 3'h1;
        if (lastBit) begin
          // All ones at or above full scale, so battery tops out at FFh
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
          result_reg <= kept; // [RULE_16] [RULE_22]
          trial_reg <= kept;
        end else begin
          trial_reg <= kept | (bitMask >> 1); // [RULE_22]
        end
      end else if (busy_reg) begin
        stepCnt_reg <= stepCnt_reg + 8'h01;
      end
    end
  end

  assign dacCode = trial_reg;
  assign busy = busy_reg;
  assign done = done_reg;
  assign result = result_reg;
endmodule : vms_sar
`default_nettype wire

// file: sim/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  import vms_pkg::*;
  // ********************************************************
  // Bench parameters and signals
  // ********************************************************
  localparam int MS_SIM = 20;
  localparam int DLY_SIM = 4;
  localparam int TIME_LIMIT = 20000;
  logic mclk;
  logic rst_n;
  logic [3:0] regAddr;
  logic regWr;
  logic regRd;
  logic [7:0] regWdata;
  logic [7:0] regRdata;
  logic cmpHigh;
  logic [7:0] dacCode;
  logic [3:0] muxSel;
  logic refInternal;
  logic irqOut;
  logic mgmtIrq_n;
  logic [7:0] vin [NUM_CH];
  logic [7:0] rdVal;
  int n_mismatch;
  int num_checks;
  int cycleCount;

  // Short count parameters keep the scan period at a few hundred cycles
  vms_monitor #(.MS_CYC(MS_SIM), .DLY_UNIT_CYC(DLY_SIM)) vms_monitor_i (
    .mclk(mclk), .rst_n(rst_n), .regAddr(regAddr), .regWr(regWr),
    .regRd(regRd), .regWdata(regWdata), .regRdata(regRdata),
    .cmpHigh(cmpHigh), .dacCode(dacCode), .muxSel(muxSel),
    .refInternal(refInternal), .irqOut(irqOut), .mgmtIrq_n(mgmtIrq_n)
  );

  // ********************************************************
  // Clock, analog comparator model and watchdog
  // ********************************************************
  initial mclk = 1'b0;
  always #20 mclk = ~mclk;

  // Input level sits half a code above vin, so a SAR lands exactly on vin
  always @(posedge mclk) begin
    cmpHigh <= (muxSel < 4'hB) ? (vin[muxSel] >= dacCode) : 1'b0;
  end

  // A hang is cut short well after the longest expected run
  always @(posedge mclk) begin
    cycleCount <= cycleCount + 1;
    if (cycleCount == TIME_LIMIT) begin
      n_mismatch++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      stop_test();
    end
  end

  // ********************************************************
  // Register access and comparison tasks
  // ********************************************************
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask : wr

  // Read data is registered, so it is sampled one edge after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    @(posedge mclk);
    #1 d = regRdata;
  endtask : rd

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic chkReg(input logic [3:0] a, input logic [7:0] exp);
    rd(a, rdVal);
    chk(rdVal, exp, "register read");
  endtask : chkReg

  task automatic chkCh(input logic [3:0] ch, input logic [3:0] a,
                       input logic [7:0] exp);
    wr(ADDR_BANK, {4'h0, ch});
    chkReg(a, exp);
  endtask : chkCh

  // Poll the done flag; bounded so a dead scan shows as a mismatch
  task automatic waitDone(input logic [3:0] ch);
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 60 && !seen; i++) begin
      wr(ADDR_BANK, {4'h0, ch});
      rd(ADDR_CCFG, rdVal);
      seen = rdVal[CCFG_DONE];
      repeat (8) @(posedge mclk);
    end
    chk({7'h00, seen}, 8'h01, "conversion done");
  endtask : waitDone

  task automatic stop_test();
    $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  // ********************************************************
  // Main sequence
  // ********************************************************
  initial begin
    rst_n = 1'b0;
    regAddr = 4'h0;
    regWr = 1'b0;
    regRd = 1'b0;
    regWdata = 8'h00;
    cmpHigh = 1'b0;
    n_mismatch = 0;
    num_checks = 0;
    cycleCount = 0;
    foreach (vin[i]) vin[i] = 8'h00;
    vin[0] = 8'hB0;
    vin[1] = 8'h10;
    vin[8] = 8'h10;
    vin[9] = 8'hFF;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    chkReg(ADDR_BANK, 8'h00);
    chkReg(ADDR_RATE, 8'h05);
    // Delay code 1 so the settling counter runs past its first unit
    wr(ADDR_RATE, 8'h0D);
    chkReg(ADDR_RATE, 8'h0D);
    chkReg(4'h6, 8'h00);
    chk({7'h00, refInternal}, 8'h00, "ext ref default");
    // Channel set-up while still in standby
    wr(ADDR_BANK, 8'h09);
    chkReg(ADDR_BANK, 8'h09);
    wr(ADDR_HLIM, 8'hFF);
    wr(ADDR_LLIM, 8'h80);
    wr(ADDR_CCFG, 8'h11);
    wr(ADDR_BANK, 8'h00);
    wr(ADDR_HLIM, 8'hAA);
    wr(ADDR_LLIM, 8'hA0);
    chkReg(ADDR_HLIM, 8'hAA);
    wr(ADDR_CCFG, 8'h11);
    wr(ADDR_BANK, 8'h01);
    wr(ADDR_LLIM, 8'h20);
    wr(ADDR_CCFG, 8'h01);
    wr(ADDR_BANK, 8'h08);
    wr(ADDR_LLIM, 8'h40);
    wr(ADDR_CCFG, 8'h11);
    wr(ADDR_IRQ_LO, 8'h01);
    wr(ADDR_MGMT_HI, 8'h01);
    wr(ADDR_MCFG, 8'h00);
    // Reference select is registered one cycle behind the config write
    repeat (2) @(posedge mclk);
    chk({7'h00, refInternal}, 8'h01, "internal ref");
    waitDone(4'h9);
    // Readings, flags and events after the first scan
    chkCh(4'h0, ADDR_READ, 8'hB0);
    chkReg(ADDR_CCFG, 8'h93);
    chkCh(4'h1, ADDR_READ, 8'h10);
    chkReg(ADDR_CCFG, 8'h81);
    chkCh(4'h8, ADDR_CCFG, 8'h95);
    chkCh(4'h9, ADDR_READ, 8'hFF);
    chkReg(ADDR_CCFG, 8'h91);
    chkCh(4'h2, ADDR_CCFG, 8'h00);
    chkReg(ADDR_EVT_LO, 8'h01);
    chkReg(ADDR_EVT_HI, 8'h01);
    chk({7'h00, irqOut}, 8'h01, "irq raised");
    chk({7'h00, mgmtIrq_n}, 8'h00, "mgmt raised");
    // Reading equal to the high limit is in range; old flag must stick
    vin[0] = 8'hAA;
    repeat (40) @(posedge mclk);
    wr(ADDR_BANK, 8'h00);
    wr(ADDR_CCFG, 8'h91);
    waitDone(4'h0);
    chkReg(ADDR_CCFG, 8'h93);
    chkReg(ADDR_READ, 8'hAA);
    chk({7'h00, irqOut}, 8'h01, "irq held");
    // Software clears the flag and the event, then masks the other output
    wr(ADDR_CCFG, 8'h13);
    wr(ADDR_EVT_LO, 8'h01);
    chkReg(ADDR_CCFG, 8'h91);
    chkReg(ADDR_EVT_LO, 8'h00);
    chk({7'h00, irqOut}, 8'h00, "irq cleared");
    chkReg(ADDR_EVT_HI, 8'h01);
    wr(ADDR_MGMT_HI, 8'h00);
    chkReg(ADDR_MGMT_HI, 8'h00);
    chk({7'h00, mgmtIrq_n}, 8'h01, "mgmt masked");
    // Back to standby: no more conversions complete
    wr(ADDR_MCFG, 8'h03);
    repeat (2) @(posedge mclk);
    chk({7'h00, refInternal}, 8'h00, "ext ref again");
    repeat (60) @(posedge mclk);
    wr(ADDR_BANK, 8'h00);
    wr(ADDR_CCFG, 8'h91);
    repeat (400) @(posedge mclk);
    chkReg(ADDR_CCFG, 8'h11);
    stop_test();
  end
endmodule : tb
`default_nettype wire
